// file: hw/health_pkg.sv
package health_pkg;

  // Register indexes; the byte address is four times the index
  localparam logic [3:0] IDX_CTRL     = 4'h0;
  localparam logic [3:0] IDX_HEALTH   = 4'h6;
  localparam logic [3:0] IDX_INT_ADDR = 4'h8;
  localparam logic [3:0] IDX_MON_INIT = 4'h9;
  localparam logic [3:0] IDX_MON_PTR  = 4'ha;
  localparam logic [3:0] IDX_IRQ_STAT = 4'hb;
  localparam logic [3:0] IDX_IRQ_MASK = 4'hc;

  // Health status word flag positions
  localparam int HB_MEM_FAIL   = 15;
  localparam int HB_LOOPBACK   = 14;
  localparam int HB_TA_PARITY  = 13;
  localparam int HB_SELFTEST   = 12;
  localparam int HB_TIMEOUT_A  = 11;
  localparam int HB_TIMEOUT_B  = 10;
  localparam int USER_BITS_W   = 10;

  // Control register: block count field and the unsupported bits
  localparam int CTRL_CNT_LSB  = 8;
  localparam int CNT_W         = 8;
  localparam logic [15:0] CTRL_WR_MASK = 16'hff00;

  // Interrupt status bit positions
  localparam int IRQ_BLOCK     = 0;
  localparam int IRQ_HEALTH    = 1;
  localparam int IRQ_W         = 2;

  // Reset values
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  localparam logic [15:0] MON_INIT_RST = 16'h0000;
  localparam logic [5:0]  HEALTH_HI_RST = 6'h00;

  // Descriptor spacing in words
  localparam logic [15:0] DESC_STRIDE  = 16'h0008;

endpackage

// file: hw/health_word_and_monitor_wrap.sv
`timescale 1ns/10ps
// Function
// - Count N captures, interrupt, pointer still steps
// - Each descriptor eight words past previous
// - One more capture, then reload pointer
// - After reload, continue from initial address
// - Interrupt address word gets Nth descriptor
// - Auto health flags, no started self-test
// - Bit 15 set on memory access fail
// - Bit 14 set on loopback failure
// - Bit 13 set on address parity error
// - Bit 12 changes only by software
// - Bit 11 set on bus A timeout
// - Bit 10 set on bus B timeout
// - Bits 9..0 change only by software
// - Software writes set all bits, clear all but same-cycle hardware flags
// - Bits 9..0 reset to version code
// - No buffered mode, control bit 6 ignored
module health_word_and_monitor_wrap #(
  // Arbitrary value standing in for the release's version code
  parameter logic [9:0] VERSION_CODE = 10'h0a5
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mem_access_fail,
  input  wire logic        loopback_fail,
  input  wire logic        term_addr_parity_err,
  input  wire logic        tx_timeout_a,
  input  wire logic        tx_timeout_b,
  input  wire logic        msg_captured,
  output logic      [15:0] mon_desc_addr,
  output logic             block_count_pulse,
  output logic             irq
);

  logic [15:0]         ctrl_q;
  logic [15:0]         health_q;
  logic [15:0]         health_d;
  logic [15:0]         int_addr_q;
  logic [15:0]         mon_init_q;
  logic [15:0]         ptr_q;
  logic [health_pkg::CNT_W-1:0] cnt_q;
  logic                wrap_pend_q;
  logic [health_pkg::IRQ_W-1:0] stat_q;
  logic [health_pkg::IRQ_W-1:0] mask_q;
  logic [health_pkg::IRQ_W-1:0] stat_ev;
  logic [31:0]         prdata_q;
  logic                pready_q;
  logic                pslverr_q;
  logic                irq_q;
  logic                blk_q;
  logic [15:0]         hw_set;
  logic [15:0]         rd_val;
  logic                mapped;
  logic                acc_first;
  logic                acc_done;
  logic                wr_en;
  logic                rd_en;
  logic [3:0]          idx;
  logic [health_pkg::CNT_W-1:0] blk_n;
  logic                blk_hit;
  logic                init_wr;

  assign idx   = paddr[5:2];
  assign blk_n = ctrl_q[health_pkg::CTRL_CNT_LSB +: health_pkg::CNT_W];

  // One wait state so read data can come from a flop
  assign acc_first = psel & penable & ~pready_q;
  assign acc_done  = psel & penable & pready_q;
  assign wr_en     = acc_done & pwrite & mapped;
  assign rd_en     = acc_done & ~pwrite & mapped;
  assign init_wr   = wr_en & (idx == health_pkg::IDX_MON_INIT);

  // Address decode; upper address bits must be zero
  always_comb begin
    mapped = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00);
    rd_val = 16'h0000;
    case (idx)
      health_pkg::IDX_CTRL:     rd_val = ctrl_q;
      health_pkg::IDX_HEALTH:   rd_val = health_q;
      health_pkg::IDX_INT_ADDR: rd_val = int_addr_q;
      health_pkg::IDX_MON_INIT: rd_val = mon_init_q;
      health_pkg::IDX_MON_PTR:  rd_val = ptr_q;
      health_pkg::IDX_IRQ_STAT: rd_val = {14'h0000, stat_q};
      health_pkg::IDX_IRQ_MASK: rd_val = {14'h0000, mask_q};
      default:                  mapped = 1'b0;
    endcase
  end

  // APB answer: pready one cycle after the access phase opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc_first;
      pslverr_q <= acc_first & ~mapped;
      if (acc_first) begin
        prdata_q <= mapped ? {16'h0000, rd_val} : 32'h0000_0000;
      end
    end
  end

  // Control register; self-test start and buffer mode bits do not exist
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= health_pkg::CTRL_RST;
    end else if (wr_en && idx == health_pkg::IDX_CTRL) begin
      ctrl_q <= pwdata[15:0] & health_pkg::CTRL_WR_MASK;
    end
  end

  // Hardware event sources for the health word
  always_comb begin
    hw_set = 16'h0000;
    hw_set[health_pkg::HB_MEM_FAIL]  = mem_access_fail;
    hw_set[health_pkg::HB_LOOPBACK]  = loopback_fail;
    hw_set[health_pkg::HB_TA_PARITY] = term_addr_parity_err;
    hw_set[health_pkg::HB_TIMEOUT_A] = tx_timeout_a;
    hw_set[health_pkg::HB_TIMEOUT_B] = tx_timeout_b;
  end

  // Health word next value; bit 12 and 9..0 have no hardware source
  always_comb begin
    health_d = health_q;
    if (wr_en && idx == health_pkg::IDX_HEALTH) begin
      health_d = pwdata[15:0];
    end
    health_d = health_d | hw_set;
  end

  // Health word register, version code in low bits at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      health_q <= {health_pkg::HEALTH_HI_RST, VERSION_CODE};
    end else begin
      health_q <= health_d;
    end
  end

  // Monitor initial descriptor pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_init_q <= health_pkg::MON_INIT_RST;
    end else if (init_wr) begin
      mon_init_q <= pwdata[15:0];
    end
  end

  // Nth capture of a block; a zero count disables blocks
  assign blk_hit = msg_captured & ~wrap_pend_q & ~init_wr &
                   (blk_n != '0) &
                   (cnt_q + 1'b1 == blk_n);

  // Descriptor pointer walk; programming the start restarts the walk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q       <= health_pkg::MON_INIT_RST;
      cnt_q       <= '0;
      wrap_pend_q <= 1'b0;
    end else if (init_wr) begin
      ptr_q       <= pwdata[15:0];
      cnt_q       <= '0;
      wrap_pend_q <= 1'b0;
    end else if (msg_captured) begin
      if (wrap_pend_q) begin
        ptr_q       <= mon_init_q;
        cnt_q       <= '0;
        wrap_pend_q <= 1'b0;
      end else begin
        ptr_q <= ptr_q + health_pkg::DESC_STRIDE;
        // count; the pointer still steps at block end
        cnt_q       <= blk_hit ? '0 : cnt_q + 1'b1;
        wrap_pend_q <= blk_hit;
      end
    end
  end

  // Interrupt address word and block pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_addr_q <= 16'h0000;
      blk_q <= 1'b0;
    end else begin
      blk_q <= blk_hit;
      if (blk_hit) begin
        int_addr_q <= ptr_q;
      end
    end
  end

  // Interrupt events: block count and any new health flag
  assign stat_ev[health_pkg::IRQ_BLOCK]  = blk_hit;
  assign stat_ev[health_pkg::IRQ_HEALTH] = |(hw_set & ~health_q);

  // Sticky status cleared by a read; an event in the same cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
    end else if (rd_en && idx == health_pkg::IDX_IRQ_STAT) begin
      stat_q <= stat_ev;
    end else begin
      stat_q <= stat_q | stat_ev;
    end
  end

  // Interrupt mask, one bit per status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else if (wr_en && idx == health_pkg::IDX_IRQ_MASK) begin
      mask_q <= pwdata[health_pkg::IRQ_W-1:0];
    end
  end

  // Level interrupt, registered so it lags status by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign mon_desc_addr     = ptr_q;
  assign block_count_pulse = blk_q;
  assign irq               = irq_q;

  // Steps of a block end: Nth capture, then the extra capture
  sequence s_nth_capture;
    blk_hit;
  endsequence

  sequence s_extra_capture;
    msg_captured && wrap_pend_q && !init_wr;
  endsequence

  a_mem_fail_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    mem_access_fail |=> health_q[health_pkg::HB_MEM_FAIL])
    else $error("memory fail flag not set");

  a_loop_fail_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    loopback_fail |=> health_q[health_pkg::HB_LOOPBACK])
    else $error("loopback flag not set");

  a_parity_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    term_addr_parity_err |=> health_q[health_pkg::HB_TA_PARITY])
    else $error("parity flag not set");

  a_timeout_a_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    tx_timeout_a |=> health_q[health_pkg::HB_TIMEOUT_A])
    else $error("bus A timeout flag not set");

  a_timeout_b_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    tx_timeout_b |=> health_q[health_pkg::HB_TIMEOUT_B])
    else $error("bus B timeout flag not set");

  a_soft_bits_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_en && idx == health_pkg::IDX_HEALTH) |=>
      $stable(health_q[12]) && $stable(health_q[9:0]))
    else $error("software-only health bits changed");

  a_health_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && idx == health_pkg::IDX_HEALTH) |=>
      health_q == ($past(pwdata[15:0]) | $past(hw_set)))
    else $error("health write value wrong");

  a_stride_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    (msg_captured && !wrap_pend_q && !init_wr) |=>
      ptr_q == $past(ptr_q) + health_pkg::DESC_STRIDE)
    else $error("descriptor stride wrong");

  a_block_addr: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_nth_capture |=> block_count_pulse && wrap_pend_q &&
      int_addr_q == $past(ptr_q))
    else $error("block end handling wrong");

  // The pending wrap is the state left by the Nth capture
  a_wrap_reload: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_extra_capture |=>
      ptr_q == mon_init_q && !wrap_pend_q && cnt_q == '0)
    else $error("pointer not reloaded after extra capture");

  a_init_restart: assert property (
    @(posedge pclk) disable iff (!presetn)
    init_wr |=> ptr_q == $past(pwdata[15:0]) && cnt_q == '0)
    else $error("pointer not restarted by init write");

  a_irq_raise: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|(stat_q & mask_q)) |=> irq)
    else $error("interrupt not raised");

  a_irq_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(|(stat_q & mask_q)) |=> !irq)
    else $error("interrupt not dropped");

  a_stat_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd_en && idx == health_pkg::IDX_IRQ_STAT && stat_ev == '0) |=>
      stat_q == '0)
    else $error("status not cleared by read");

  a_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");

  a_err_with_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

endmodule

// file: tb/capture_source.sv
`timescale 1ns/10ps
// Stands in for the bus side that stores monitored messages
module capture_source (
  input  wire logic        pclk,
  input  wire logic [15:0] mon_desc_addr,
  input  wire logic        block_count_pulse,
  output logic             msg_captured
);
  logic [15:0] seen_q[$];
  int          blk_at;
  int          n_blocks;

  initial msg_captured = 1'b0;

  // Log the pointer at each taken capture; the block pulse is counted
  // before the push so back-to-back captures do not skew it
  always @(posedge pclk) begin
    if (block_count_pulse === 1'b1) begin
      blk_at = seen_q.size();
      n_blocks++;
    end
    if (msg_captured === 1'b1) seen_q.push_back(mon_desc_addr);
  end

  // Gap of zero gives back-to-back captures, the tightest spacing
  task automatic capture(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      msg_captured <= 1'b1;
      repeat (gap) begin
        @(posedge pclk);
        msg_captured <= 1'b0;
      end
    end
    @(posedge pclk);
    msg_captured <= 1'b0;
  endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam logic [9:0] VER = 10'h15a; // Arbitrary version code
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq, msg_captured, block_count_pulse, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] mon_desc_addr;
  logic [4:0]  ev;
  int          n_errors, n_checks;

  health_word_and_monitor_wrap #(
    .VERSION_CODE(VER)
  ) health_word_and_monitor_wrap_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_access_fail(ev[0]),
    .loopback_fail(ev[1]), .term_addr_parity_err(ev[2]),
    .tx_timeout_a(ev[3]), .tx_timeout_b(ev[4]),
    .msg_captured(msg_captured), .mon_desc_addr(mon_desc_addr),
    .block_count_pulse(block_count_pulse), .irq(irq));

  capture_source capture_source_i (
    .pclk(pclk), .mon_desc_addr(mon_desc_addr),
    .block_count_pulse(block_count_pulse), .msg_captured(msg_captured));

  // Free-running core clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic conclude;
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [3:0] idx,
                     input logic [15:0] wd);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 16'h0000);
    chk("register read", rdat, exp);
  endtask

  task automatic t_reset_values;
    logic [31:0] rst_exp;
    rst_exp = {16'h0000, health_pkg::HEALTH_HI_RST, VER};
    // Outputs still at reset levels before any traffic
    chk("pointer reset", 32'(mon_desc_addr), 32'h0000_0000);
    chk("irq reset", 32'(irq), 32'h0000_0000);
    chk("pulse reset", 32'(block_count_pulse), 32'h0000_0000);
    rdc(health_pkg::IDX_HEALTH, rst_exp);
    apb(1'b0, 4'h3, 16'h0000);
    chk("unmapped error", 32'(rerr), 32'h0000_0001);
    chk("unmapped data", rdat, 32'h0000_0000);
  endtask

  // Only the block count field may stick; no buffer or self-test bits
  task automatic t_ctrl_bits;
    apb(1'b1, health_pkg::IDX_CTRL, 16'hffff);
    rdc(health_pkg::IDX_CTRL, 32'(health_pkg::CTRL_WR_MASK));
    chk("self-test bits", rdat & 32'h0000_00ff, 32'h0000_0000);
  endtask

  task automatic t_health_flags;
    int          hb[5];
    logic [31:0] hx;
    hb = '{health_pkg::HB_MEM_FAIL, health_pkg::HB_LOOPBACK,
           health_pkg::HB_TA_PARITY, health_pkg::HB_TIMEOUT_A,
           health_pkg::HB_TIMEOUT_B};
    apb(1'b1, health_pkg::IDX_IRQ_MASK, 16'h0002);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, health_pkg::IDX_HEALTH, 16'h0000);
      @(posedge pclk);
      ev <= 5'b00001 << i;
      @(posedge pclk);
      ev <= 5'b00000;
      repeat (3) @(posedge pclk);
      chk("irq", 32'(irq), 32'h0000_0001);
      hx = 32'h0000_0001 << hb[i];
      apb(1'b0, health_pkg::IDX_HEALTH, 16'h0000);
      chk("flag", rdat, hx);
      chk("sw bits", rdat & 32'h0000_13ff, 32'h0000_0000);
      rdc(health_pkg::IDX_IRQ_STAT, 32'h0000_0002);
    end
    repeat (3) @(posedge pclk);
    chk("irq", 32'(irq), 32'h0000_0000);
    apb(1'b1, health_pkg::IDX_HEALTH, 16'hffff);
    rdc(health_pkg::IDX_HEALTH, 32'h0000_ffff);
  endtask

  // Event held across the clearing write must survive it
  task automatic t_set_wins;
    @(posedge pclk);
    ev <= 5'b00001;
    apb(1'b1, health_pkg::IDX_HEALTH, 16'h0000);
    ev <= 5'b00000;
    rdc(health_pkg::IDX_HEALTH, 32'h0000_8000);
    apb(1'b1, health_pkg::IDX_HEALTH, 16'h0000);
    rdc(health_pkg::IDX_HEALTH, 32'h0000_0000);
  endtask

  task automatic t_monitor_wrap;
    logic [15:0] exp[7];
    logic [15:0] got;
    exp = '{16'h2000, 16'h2008, 16'h2010, 16'h2018,
            16'h2020, 16'h2000, 16'h2008};
    apb(1'b1, health_pkg::IDX_IRQ_MASK, 16'h0001);
    apb(1'b0, health_pkg::IDX_IRQ_STAT, 16'h0000);
    apb(1'b1, health_pkg::IDX_CTRL, 16'h0400);
    apb(1'b1, health_pkg::IDX_MON_INIT, 16'h2000);
    rdc(health_pkg::IDX_MON_PTR, 32'h0000_2000);
    capture_source_i.capture(5, 2);
    capture_source_i.capture(2, 0);
    repeat (3) @(posedge pclk);
    chk("captures", capture_source_i.seen_q.size(), 32'd7);
    for (int i = 0; i < 7; i++) begin
      got = capture_source_i.seen_q[i];
      chk("descriptor", 32'(got), 32'(exp[i]));
    end
    chk("block position", capture_source_i.blk_at, 32'd4);
    chk("block count", capture_source_i.n_blocks, 32'd1);
    chk("irq", 32'(irq), 32'h0000_0001);
    rdc(health_pkg::IDX_INT_ADDR, 32'h0000_2018);
    rdc(health_pkg::IDX_IRQ_STAT, 32'h0000_0001);
  endtask

  // Main sequence: reset for five cycles, then each scenario in turn
  initial begin
    n_errors = 0;
    n_checks = 0;
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0000_0000;
    ev       = 5'b00000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_ctrl_bits();
    t_health_flags();
    t_set_wins();
    t_monitor_wrap();
    conclude();
  end
endmodule
